// ===== hw/sense_pkg.sv
// Constants for the capacitive sense control block.
// Assumes an 8-bit register port with two registers at word indices 0 and 1.
package sense_pkg;
   // Register indices
   localparam logic [0:0] OFS_SENSE_CONTROL        = 1'h0;
   localparam logic [0:0] OFS_SENSE_CHANNEL_SELECT = 1'h1;
   // Control and channel register field positions
   localparam int BIT_MODULE_ENABLE   = 7;
   localparam int BIT_RANGE_SELECT    = 6;
   localparam int BIT_CURRENT_HI      = 3;
   localparam int BIT_CURRENT_LO      = 2;
   localparam int BIT_SOURCE_SINK     = 1;
   localparam int BIT_T0_EXT_SELECT   = 0;
   localparam int BIT_CHANNEL_HI      = 3;
   // Reset values
   localparam logic [7:0] RST_SENSE_CONTROL        = 8'h00;
   localparam logic [7:0] RST_SENSE_CHANNEL_SELECT = 8'h00;
   localparam logic [7:0] RST_READ_DATA            = 8'h00;
   // Current codes
   localparam logic [1:0] CUR_OFF_OR_NOISE = 2'h0;
   localparam logic [1:0] CUR_LOW          = 2'h1;
   localparam logic [1:0] CUR_MEDIUM       = 2'h2;
   localparam logic [1:0] CUR_HIGH         = 2'h3;
   // Channel codes and counts
   localparam int         NUM_CHANNELS     = 12;
   localparam logic [3:0] CHAN_LAST_SMALL  = 4'h7;
   localparam logic [3:0] CHAN_LAST_LARGE  = 4'hb;
   // Timer one clock source code for the sensing oscillator
   localparam logic [1:0] T1_SRC_SENSE_OSC = 2'h3;
   // Synchroniser depth
   localparam int         SYNC_STAGES      = 3;
endpackage

// ===== hw/capacitive_sense_control.sv
// Capacitive sense control: settings registers, channel select, oscillator status and timer clock steering.
// Assumes a single-cycle register port on i_core_clk; oscillator signals and the timer pin are asynchronous.
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Enable bit switches oscillator, current and channels on
// - Range bit selects high or low thresholds
// - Unused bits ignore writes, read zero
// - Low range: code 00 off, else current
// - High range code 00: noise detection
// - High range codes select charge current
// - Status reads one when sourcing current
// - Select bit routes oscillator or pin
// - Internal clock: timer counts instruction tick
// - Channel codes 0-7 pick channels 0-7
// - Codes 8-11 only on large package
// - Disabled module connects no channel
// - All bits clear on every reset
// - Oscillator runs in sleep while enabled
// - Timer zero stops during sleep
// - Counting in sleep, evaluation awake
// - Timer one code 11 takes oscillator
module capacitive_sense_control #(
   parameter bit LARGE_PACKAGE = 1'b1
) (
   input  wire logic        i_core_clk,
   input  wire logic        i_rst_n,
   input  wire logic [0:0]  i_addr,
   input  wire logic [7:0]  i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   input  wire logic        i_osc_source_sink,
   input  wire logic        i_osc_clk,
   input  wire logic        i_timer_zero_clock_pin,
   input  wire logic        i_timer_zero_clock_select,
   input  wire logic [1:0]  i_timer_one_clock_select,
   input  wire logic        i_instr_tick,
   input  wire logic        i_sleep,
   output logic [7:0]       o_rdata,
   output logic             o_sense_module_enable,
   output logic             o_reference_range_select,
   output logic             o_osc_run,
   output logic             o_charge_current_en,
   output logic             o_noise_detect,
   output logic [1:0]       o_current_level,
   output logic [11:0]      o_sense_pin_connect,
   output logic             o_timer_zero_tick,
   output logic             o_timer_one_tick
);

   typedef struct packed {
      logic        en;
      logic        rm;
      logic [1:0]  rng;
      logic        timer_zero_ext_source_select;
      logic [3:0]  chan;
      logic [7:0]  rdata;
      logic [2:0]  flag_sync;
      logic [2:0]  osc_sync;
      logic [2:0]  pin_sync;
      logic        flag;
      logic        osc_lvl;
      logic        pin_lvl;
      logic        t0_tick;
      logic        t1_tick;
      logic        osc_run;
      logic        cur_en;
      logic        noise;
      logic [1:0]  level;
      logic [11:0] connect;
   } state_t;

   state_t st_r;
   state_t st_nxt;
   logic   rst_meta_r;
   logic   rst_sync_r;

   // Reset release through two flops
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end

   // One-hot channel connection from enable and code
   function automatic logic [11:0] chan_decode(input logic en, input logic [3:0] code);
      logic [3:0] last;
      chan_decode = 12'h000;
      last = LARGE_PACKAGE ? sense_pkg::CHAN_LAST_LARGE : sense_pkg::CHAN_LAST_SMALL;
      if (en && (code <= last)) begin
         chan_decode[code] = 1'b1;
      end
   endfunction

   // Filtered level: changes once the last two stages agree
   function automatic logic filt(input logic [2:0] s, input logic old);
      filt = (s[1] == s[2]) ? s[2] : old;
   endfunction

   logic ctrl_hit;
   logic chsel_hit;
   logic osc_edge;
   logic pin_edge;
   logic t0_src;

   always_comb begin
      st_nxt = st_r;
      ctrl_hit  = (i_addr == sense_pkg::OFS_SENSE_CONTROL);
      chsel_hit = (i_addr == sense_pkg::OFS_SENSE_CHANNEL_SELECT);

      // Register writes; unused bits are not stored
      if (i_wr && ctrl_hit) begin
         st_nxt.en    = i_wdata[sense_pkg::BIT_MODULE_ENABLE];
         st_nxt.rm    = i_wdata[sense_pkg::BIT_RANGE_SELECT];
         st_nxt.rng   = i_wdata[sense_pkg::BIT_CURRENT_HI:sense_pkg::BIT_CURRENT_LO];
         st_nxt.timer_zero_ext_source_select = i_wdata[sense_pkg::BIT_T0_EXT_SELECT];
      end
      if (i_wr && chsel_hit) begin
         st_nxt.chan = i_wdata[sense_pkg::BIT_CHANNEL_HI:0];
      end

      // Asynchronous inputs through three stages
      st_nxt.flag_sync = {st_r.flag_sync[1:0], i_osc_source_sink};
      st_nxt.osc_sync  = {st_r.osc_sync[1:0], i_osc_clk};
      st_nxt.pin_sync  = {st_r.pin_sync[1:0], i_timer_zero_clock_pin};
      st_nxt.flag      = filt(st_r.flag_sync, st_r.flag);
      st_nxt.osc_lvl   = filt(st_r.osc_sync, st_r.osc_lvl);
      st_nxt.pin_lvl   = filt(st_r.pin_sync, st_r.pin_lvl);

      // Read data, valid only in the cycle after the strobe
      st_nxt.rdata = sense_pkg::RST_READ_DATA;
      if (i_rd && ctrl_hit) begin
         st_nxt.rdata[sense_pkg::BIT_MODULE_ENABLE] = st_r.en;
         st_nxt.rdata[sense_pkg::BIT_RANGE_SELECT]  = st_r.rm;
         st_nxt.rdata[sense_pkg::BIT_CURRENT_HI:sense_pkg::BIT_CURRENT_LO] = st_r.rng;
         st_nxt.rdata[sense_pkg::BIT_SOURCE_SINK]   = st_r.flag;
         st_nxt.rdata[sense_pkg::BIT_T0_EXT_SELECT] = st_r.timer_zero_ext_source_select;
      end else if (i_rd && chsel_hit) begin
         st_nxt.rdata[sense_pkg::BIT_CHANNEL_HI:0] = st_r.chan;
      end

      // Oscillator mode from the new settings; sleep plays no part
      st_nxt.osc_run = st_nxt.en && (st_nxt.rm || (st_nxt.rng != sense_pkg::CUR_OFF_OR_NOISE));
      st_nxt.noise   = st_nxt.en && st_nxt.rm && (st_nxt.rng == sense_pkg::CUR_OFF_OR_NOISE);
      st_nxt.cur_en  = st_nxt.en && (st_nxt.rng != sense_pkg::CUR_OFF_OR_NOISE);
      st_nxt.level   = st_nxt.cur_en ? st_nxt.rng : sense_pkg::CUR_OFF_OR_NOISE;
      st_nxt.connect = chan_decode(st_nxt.en, st_nxt.chan);

      // Timer clock steering
      osc_edge = st_nxt.osc_lvl && !st_r.osc_lvl && st_r.osc_run;
      pin_edge = st_nxt.pin_lvl && !st_r.pin_lvl;
      if (i_timer_zero_clock_select) begin
         t0_src = st_r.timer_zero_ext_source_select ? osc_edge : pin_edge;
      end else begin
         t0_src = i_instr_tick;
      end
      st_nxt.t0_tick = t0_src && !i_sleep;
      st_nxt.t1_tick = osc_edge && (i_timer_one_clock_select == sense_pkg::T1_SRC_SENSE_OSC);
   end

   always_ff @(posedge i_core_clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_rdata                  = st_r.rdata;
   assign o_sense_module_enable    = st_r.en;
   assign o_reference_range_select = st_r.rm;
   assign o_osc_run                = st_r.osc_run;
   assign o_charge_current_en      = st_r.cur_en;
   assign o_noise_detect           = st_r.noise;
   assign o_current_level          = st_r.level;
   assign o_sense_pin_connect      = st_r.connect;
   assign o_timer_zero_tick        = st_r.t0_tick;
   assign o_timer_one_tick         = st_r.t1_tick;

   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!rst_sync_r);

   sequence s_enable_write;
      i_wr && (i_addr == sense_pkg::OFS_SENSE_CONTROL) && i_wdata[sense_pkg::BIT_MODULE_ENABLE];
   endsequence

   sequence s_disable_write;
      i_wr && (i_addr == sense_pkg::OFS_SENSE_CONTROL) && !i_wdata[sense_pkg::BIT_MODULE_ENABLE];
   endsequence

   sequence s_ctrl_read;
      i_rd && (i_addr == sense_pkg::OFS_SENSE_CONTROL);
   endsequence

   sequence s_chsel_read;
      i_rd && (i_addr == sense_pkg::OFS_SENSE_CHANNEL_SELECT);
   endsequence

   sequence s_flag_high_steady;
      i_osc_source_sink [*4];
   endsequence

   sequence s_ctrl_write;
      i_wr && (i_addr == sense_pkg::OFS_SENSE_CONTROL);
   endsequence

   sequence s_chsel_write_low;
      i_wr && (i_addr == sense_pkg::OFS_SENSE_CHANNEL_SELECT) && !i_wdata[sense_pkg::BIT_CHANNEL_HI]
      && o_sense_module_enable;
   endsequence

   sequence s_flag_low_steady;
      (!i_osc_source_sink) [*4];
   endsequence

   // Tick sources: qualifiers in one cycle, filtered rising level in the next
   sequence s_t0_osc_edge;
      i_timer_zero_clock_select && st_r.timer_zero_ext_source_select && !i_sleep && st_r.osc_run ##1 $rose(st_r.osc_lvl);
   endsequence

   sequence s_t0_pin_edge;
      i_timer_zero_clock_select && !st_r.timer_zero_ext_source_select && !i_sleep ##1 $rose(st_r.pin_lvl);
   endsequence

   sequence s_t1_osc_edge;
      (i_timer_one_clock_select == sense_pkg::T1_SRC_SENSE_OSC) && st_r.osc_run ##1 $rose(st_r.osc_lvl);
   endsequence

   AST_ENABLE_ON: assert property (s_enable_write |=> o_sense_module_enable)
      else $error("enable bit not set by write");

   AST_ENABLE_OFF: assert property (s_disable_write |=> !o_sense_module_enable && !o_osc_run)
      else $error("module still on after disable write");

   AST_RANGE: assert property (s_ctrl_write |=> o_reference_range_select == $past(i_wdata[sense_pkg::BIT_RANGE_SELECT]))
      else $error("range output wrong");

   AST_CTRL_UNUSED: assert property (s_ctrl_read |=> o_rdata[5:4] == 2'h0)
      else $error("unused control bits read nonzero");

   AST_CHSEL_UNUSED: assert property (s_chsel_read |=> o_rdata[7:4] == 4'h0 && o_rdata[3:0] == $past(st_r.chan))
      else $error("channel register read wrong");

   AST_LOW_OFF: assert property (!st_r.rm && st_r.rng == sense_pkg::CUR_OFF_OR_NOISE |-> !o_osc_run && !o_charge_current_en)
      else $error("oscillator runs with low range code zero");

   AST_NOISE: assert property (st_r.en && st_r.rm && st_r.rng == sense_pkg::CUR_OFF_OR_NOISE
                               |-> o_osc_run && o_noise_detect && !o_charge_current_en)
      else $error("noise detection mode wrong");

   AST_LEVEL: assert property (st_r.en && st_r.rng != sense_pkg::CUR_OFF_OR_NOISE
                               |-> o_current_level == st_r.rng && o_charge_current_en && o_osc_run)
      else $error("current level does not follow code");

   AST_STATUS: assert property (s_ctrl_read |=> o_rdata[sense_pkg::BIT_SOURCE_SINK] == $past(st_r.flag))
      else $error("status bit read wrong");

   AST_T0_INTERNAL: assert property (!i_timer_zero_clock_select && !i_sleep && i_instr_tick |=> o_timer_zero_tick)
      else $error("timer zero missed instruction tick");

   AST_T0_SLEEP: assert property (i_sleep |=> !o_timer_zero_tick)
      else $error("timer zero ticked during sleep");

   AST_CHAN_OFF: assert property (!o_sense_module_enable |-> o_sense_pin_connect == 12'h000)
      else $error("channel connected while disabled");

   AST_CHAN_MAP: assert property (o_sense_module_enable && st_r.chan <= sense_pkg::CHAN_LAST_SMALL
                                  |-> o_sense_pin_connect == (12'h001 << st_r.chan))
      else $error("channel connection wrong");

   AST_T1_SOURCE: assert property (i_timer_one_clock_select != sense_pkg::T1_SRC_SENSE_OSC |=> !o_timer_one_tick)
      else $error("timer one ticked without oscillator source");

   AST_SYNC: assert property (s_flag_high_steady |=> ##1 st_r.flag)
      else $error("status flag not synchronised in time");

   AST_SYNC_LOW: assert property (s_flag_low_steady |=> ##1 !st_r.flag)
      else $error("status flag not cleared in time");

   AST_RESET_CLEAR: assert property ($rose(rst_sync_r)
                                     |-> o_rdata == sense_pkg::RST_READ_DATA && !o_sense_module_enable
                                     && !o_osc_run && o_sense_pin_connect == 12'h000)
      else $error("outputs not clear after reset");

   AST_RDATA_IDLE: assert property (!i_rd |=> o_rdata == sense_pkg::RST_READ_DATA)
      else $error("read data not cleared");

   AST_CTRL_FIELDS: assert property (s_ctrl_read |=>
                                     o_rdata[sense_pkg::BIT_MODULE_ENABLE] == $past(o_sense_module_enable)
                                     && o_rdata[sense_pkg::BIT_RANGE_SELECT] == $past(o_reference_range_select)
                                     && o_rdata[sense_pkg::BIT_T0_EXT_SELECT] == $past(st_r.timer_zero_ext_source_select))
      else $error("control register read wrong");

   AST_EXTRA_CHAN: assert property (o_sense_module_enable && st_r.chan > sense_pkg::CHAN_LAST_SMALL
                                    && st_r.chan <= sense_pkg::CHAN_LAST_LARGE
                                    |-> o_sense_pin_connect[st_r.chan] == LARGE_PACKAGE)
      else $error("extra channel connection wrong");

   AST_ONE_HOT: assert property ($onehot0(o_sense_pin_connect))
      else $error("more than one channel connected");

   AST_WRITE_CHAN: assert property (s_chsel_write_low |=>
                                    o_sense_pin_connect == (12'h001 << $past(i_wdata[sense_pkg::BIT_CHANNEL_HI - 1:0])))
      else $error("low channel code not connected");

   AST_DISABLE_QUIET: assert property (!o_sense_module_enable
                                       |-> !o_osc_run && !o_charge_current_en && !o_noise_detect
                                       && o_current_level == sense_pkg::CUR_OFF_OR_NOISE)
      else $error("settings active while disabled");

   AST_NOISE_LEVEL: assert property (o_noise_detect
                                     |-> o_reference_range_select && o_osc_run
                                     && o_current_level == sense_pkg::CUR_OFF_OR_NOISE)
      else $error("noise mode with current level set");

   AST_CUR_LOW: assert property (s_enable_write ##0
                                 i_wdata[sense_pkg::BIT_CURRENT_HI:sense_pkg::BIT_CURRENT_LO] == sense_pkg::CUR_LOW
                                 |=> o_current_level == sense_pkg::CUR_LOW && o_charge_current_en)
      else $error("low current code not applied");

   AST_SLEEP_OSC: assert property (i_sleep && o_osc_run && !i_wr |=> o_osc_run)
      else $error("oscillator stopped by sleep");

   AST_T0_OSC: assert property (s_t0_osc_edge |-> o_timer_zero_tick)
      else $error("timer zero missed oscillator edge");

   AST_T0_PIN: assert property (s_t0_pin_edge |-> o_timer_zero_tick)
      else $error("timer zero missed pin edge");

   AST_T1_OSC: assert property (s_t1_osc_edge |-> o_timer_one_tick)
      else $error("timer one missed oscillator edge");

   AST_T0_IDLE: assert property (!i_timer_zero_clock_select && !i_instr_tick |=> !o_timer_zero_tick)
      else $error("timer zero ticked without instruction tick");

   AST_OSC_GATE: assert property (!o_osc_run |=> !o_timer_one_tick)
      else $error("timer one ticked with oscillator off");

endmodule

`default_nettype wire

// ===== sim/pad_osc_model.sv
// Pad oscillator stand-in: triangle-wave comparator output and current direction.
// Assumes the core clock paces it; phases last 8 core cycles.
`timescale 1ns/1ps
`default_nettype none
module pad_osc_model (
   input  wire logic i_clk,
   input  wire logic i_run,
   input  wire logic i_freeze,
   input  wire logic i_lvl,
   output logic      o_osc,
   output logic      o_dir
);
   logic [2:0] cnt;
   initial begin
      o_osc = 1'b0;
      cnt = 3'h0;
   end
   always @(posedge i_clk) begin
      cnt <= cnt + 3'h1;
      if (i_freeze) o_osc <= i_lvl;
      else if (i_run && cnt == 3'h7) o_osc <= !o_osc;
   end
   // Sourcing while the pad charges
   assign o_dir = o_osc;
endmodule
`default_nettype wire

// ===== sim/tb.sv
// Bench for the sense control block: registers, settings outputs, timer steering.
// Assumes pad_osc_model stands in for the pad oscillator.
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        clk, rst_n, addr, wr, rd, rd_q, t0pin, pin_q, t0sel, itick, sleep;
   logic        frz, lvl, osc, osc_q, dir, en, rm, run, cen, nd, t0t, t1t;
   logic [1:0]  t1sel, lev;
   logic [7:0]  wdata, rdata, ctl, chs;
   logic [11:0] pins;
   logic [7:0]  rq[$];
   int          n_fail, samples_checked, cyc, n_osc, n_t0, n_t1, n_pin, n_it;

   capacitive_sense_control u_capacitive_sense_control (
      .i_core_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
      .i_osc_source_sink(dir), .i_osc_clk(osc), .i_timer_zero_clock_pin(t0pin),
      .i_timer_zero_clock_select(t0sel), .i_timer_one_clock_select(t1sel), .i_instr_tick(itick),
      .i_sleep(sleep), .o_rdata(rdata), .o_sense_module_enable(en), .o_reference_range_select(rm),
      .o_osc_run(run), .o_charge_current_en(cen), .o_noise_detect(nd), .o_current_level(lev),
      .o_sense_pin_connect(pins), .o_timer_zero_tick(t0t), .o_timer_one_tick(t1t));
   pad_osc_model u_pad_osc_model (.i_clk(clk), .i_run(run), .i_freeze(frz), .i_lvl(lvl),
      .o_osc(osc), .o_dir(dir));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic chkv(input logic [18:0] g, input logic [18:0] e, input string what);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value at %0t: %s %h, expected %h", $time, what, g, e);
      end
   endtask
   task automatic chkn(input int g, input int e, input int tol);
      samples_checked++;
      if (g > e + tol || g < e - tol) begin
         n_fail++;
         $display("wrong value at %0t: count %0d, expected %0d", $time, g, e);
      end
   endtask
   task automatic give_verdict;
      $display("checked %0d, failed %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      rd_q <= rd;
      osc_q <= osc;
      pin_q <= t0pin;
      t0pin <= cyc[3];
      itick <= 1'($urandom);
      if (rd_q) chkv(19'(rdata), 19'(rq.pop_front()), "read");
      n_osc <= n_osc + int'(osc & ~osc_q);
      n_pin <= n_pin + int'(t0pin & ~pin_q);
      n_it <= n_it + int'(itick);
      n_t0 <= n_t0 + int'(t0t);
      n_t1 <= n_t1 + int'(t1t);
      if (cyc == 5000) begin
         n_fail++;
         give_verdict();
      end
   end

   task automatic wr_reg(input logic a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd_reg(input logic a, input logic [7:0] e);
      addr <= a;
      rd <= 1'b1;
      rq.push_back(e);
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
   endtask
   function automatic logic [18:0] exp_out(input logic [7:0] c, input logic [7:0] h);
      logic on;
      on = c[7];
      exp_out = {on, c[6], on & (c[6] | |c[3:2]), on & |c[3:2], on & c[6] & ~|c[3:2],
                 on ? c[3:2] : 2'h0, (on && h < 8'hc) ? 12'h1 << h[3:0] : 12'h0};
   endfunction
   task automatic setup(input logic [7:0] c, input logic [7:0] h);
      ctl = c & 8'hcd;
      chs = h & 8'h0f;
      wr_reg(1'b0, c);
      wr_reg(1'b1, h);
      chkv({en, rm, run, cen, nd, lev, pins}, exp_out(ctl, chs), "outputs");
      rd_reg(1'b0, {ctl[7:2], lvl, ctl[0]});
      rd_reg(1'b1, chs);
   endtask
   task automatic win(input logic [7:0] c, input logic s0, input logic sl);
      wr_reg(1'b0, c);
      t0sel <= s0;
      sleep <= sl;
      repeat (8) @(negedge clk);
      {n_osc, n_t0, n_t1, n_pin, n_it} = 160'h0;
      repeat (200) @(negedge clk);
      @(posedge clk);
   endtask

   initial begin
      logic [7:0] r;
      r = 8'($urandom(43944));
      {rst_n, addr, wr, rd, t0sel, sleep, lvl, wdata, rd_q, osc_q, pin_q, t0pin, itick} = '0;
      frz = 1'b1;
      t1sel = 2'h3;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      chkv({en, rm, run, cen, nd, lev, pins}, 19'h0, "reset");
      rd_reg(1'b0, 8'h00);
      rd_reg(1'b1, 8'h00);
      $display("test reset done");
      for (int k = 0; k < 24; k++) begin
         r = 8'($urandom);
         setup({k >= 12, k[0], r[5:4], k[2:1], r[1:0]}, {r[7:4], 4'(k % 12)});
      end
      $display("test settings done");
      for (int k = 0; k < 2; k++) begin
         lvl <= k[0];
         repeat (8) @(posedge clk);
         setup(8'hcf, 8'h05);
      end
      $display("test status done");
      frz <= 1'b0;
      win(8'h8d, 1'b1, 1'b0);
      chkn(n_t0, n_osc, 1);
      chkn(n_t1, n_osc, 1);
      win(8'h8c, 1'b1, 1'b0);
      chkn(n_t0, n_pin, 1);
      win(8'h8d, 1'b0, 1'b0);
      chkn(n_t0, n_it, 1);
      win(8'hcd, 1'b1, 1'b1);
      chkn(n_t0, 0, 0);
      chkn(n_t1, 12, 1);
      win(8'h0d, 1'b1, 1'b0);
      chkn(n_t1, 0, 0);
      $display("test timers done");
      give_verdict();
   end
endmodule
`default_nettype wire
